// [design/twe_map.svh]
// Constants of the three-wire EEPROM command port.
// How it works
// - Serial input is sampled on each serial clock rise while select is high.
// - Read data bits leave on the serial output at serial clock rises.
// - After programming, select low 200 ns then high shows ready/busy until a start bit.
// - The serial output floats whenever select is low.
// - Select low resets the sequencer; the host drops it after every command.
// - The first one sampled after select rises while not programming is the start bit.
// - Zeros before the start bit are discarded.
// - Opcode 10 reads: 8 or 10 address bits, then 16 data bits out.
// - Opcode 01 writes one 16-bit word at the address.
// - Opcode 00 uses two address bits: 11 enable, 01 block fill, 00 lock.
// - Don't-care bits are still clocked in and either level is accepted.
// - Continued clocking after a read word streams the following addresses.
// - A word write erases the cell before programming it.
// - Block fill erases and programs all 128 words of the selected block.
// - Smallest size ignores address bit 7 and every block bit.
// - In the 8Kbit size, address bit 9 and block bit 2 are don't-care.
// - Programming runs on the internal timer, typically 7 ms, at most 10 ms.
// - Power up locked; enable persists until lock; reads work locked or enabled, but not while programming.
// - Programming starts on select fall right after the last data bit; later fall abandons.
// - While programming, new commands are ignored and the output shows busy low.
// - After the last read address bit a zero dummy bit precedes the data.
`ifndef TWE_MAP_SVH
`define TWE_MAP_SVH
`define TWE_CLK_NS 5
`define TWE_TCS_NS 200
`define TWE_PROG_NS 7000000
`define TWE_DATA_BITS 16
`define TWE_CMD_AW_MAX 10
`define TWE_CMD_AW_SMALL 8
`define TWE_SMALL_WORDS 256
`define TWE_BLOCK_WORDS 128
`define TWE_BLOCK_AW 7
`define TWE_BLK_BITS 3
`define TWE_CNT_W 5
`define TWE_OPC_BITS 2
`define TWE_OP_READ 2'h2
`define TWE_OP_WRITE 2'h1
`define TWE_OP_EXT 2'h0
`define TWE_EXT_WEN 2'h3
`define TWE_EXT_FILL 2'h1
`define TWE_EXT_LOCK 2'h0
`define TWE_ERASED 16'hFFFF
`define TWE_BUF_DEPTH 2
`endif

// [design/twe_pkg.sv]
// Types shared by the three-wire EEPROM command port.
`include "twe_map.svh"
package twe_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_OPC = 6'h02,
      ST_ADDR = 6'h04,
      ST_DATA = 6'h08,
      ST_READ = 6'h10,
      ST_DONE = 6'h20
   } twe_state_type;
   typedef struct packed {
      logic sel;
      logic clk;
      logic din;
   } twe_link_type;
   typedef struct packed {
      logic fill;
      logic [`TWE_CMD_AW_MAX-1:0] addr;
      logic [`TWE_DATA_BITS-1:0] data;
   } twe_job_type;
endpackage

// [design/twe_port.sv]
// Serial EEPROM command port: link sequencer, word store and program timer.
`include "twe_map.svh"
module twe_port
   import twe_pkg::*;
#(
   parameter int unsigned MEM_WORDS = 1024,
   parameter int unsigned PROG_CYCLES = `TWE_PROG_NS / `TWE_CLK_NS
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Serial link pins.
   input wire logic chip_sel,
   input wire logic serial_shift_clock,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   // Status.
   output logic write_enabled,
   output logic program_busy
);
   localparam int DW = `TWE_DATA_BITS;
   localparam int AW = $clog2(MEM_WORDS);
   localparam int CMD_AW = (MEM_WORDS > `TWE_SMALL_WORDS) ? `TWE_CMD_AW_MAX : `TWE_CMD_AW_SMALL;
   localparam int NBLK = MEM_WORDS / `TWE_BLOCK_WORDS;
   localparam int TCS_CYC = (`TWE_TCS_NS + `TWE_CLK_NS - 1) / `TWE_CLK_NS;
   localparam int TCSW = $clog2(TCS_CYC + 1);
   localparam int CW = `TWE_CNT_W;

   twe_link_type link_a_q;
   twe_link_type link_b_q;
   twe_link_type link_c_q;
   logic sel;
   logic din;
   logic rise;
   logic sel_fall;
   logic sel_rise;
   logic [TCSW-1:0] low_cnt_q;
   logic low_ok;
   twe_state_type state_q;
   logic [CW-1:0] bit_cnt_q;
   logic [1:0] op_q;
   logic [CMD_AW-1:0] addr_q;
   logic [DW-1:0] data_q;
   logic armed_q;
   logic wen_q;
   logic [CMD_AW-1:0] full_addr;
   logic last_addr;
   logic rd_start;
   logic start_bit;
   logic prog_start;
   logic [DW-1:0] mem_q [MEM_WORDS];
   logic fetch_on_q;
   logic [AW-1:0] fetch_q;
   logic [DW-1:0] buf_q [`TWE_BUF_DEPTH];
   logic wp_q;
   logic rp_q;
   logic [1:0] fill_q;
   logic push_valid;
   logic push_ready;
   logic pop_valid;
   logic pop_ready;
   logic [DW-1:0] sh_q;
   logic [CW-1:0] sh_cnt_q;
   logic dout_q;
   logic show_q;
   logic pend_q;
   twe_job_type job_q;
   logic busy_q;
   logic [31:0] prog_cnt_q;
   logic [31:0] span;
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;

   // Two flops on every pin, a third on clock and select for edge finding.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_a_q <= '0;
         link_b_q <= '0;
         link_c_q <= '0;
      end else begin
         link_a_q <= '{sel: chip_sel, clk: serial_shift_clock, din: serial_in};
         link_b_q <= link_a_q;
         link_c_q <= link_b_q;
      end
   end

   // Link events seen from the core clock.
   assign sel = link_b_q.sel;
   assign din = link_b_q.din;
   assign rise = sel && link_b_q.clk && !link_c_q.clk;
   assign sel_fall = !sel && link_c_q.sel;
   assign sel_rise = sel && !link_c_q.sel;

   // Measures how long select has been low, saturating at the minimum.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_q <= '0;
      end else if (sel) begin
         low_cnt_q <= '0;
      end else if (!low_ok) begin
         low_cnt_q <= low_cnt_q + 1'b1;
      end
   end
   assign low_ok = (low_cnt_q == TCSW'(TCS_CYC));

   // Command decode strobes.
   assign full_addr = {addr_q[CMD_AW-2:0], din};
   assign last_addr = rise && state_q == ST_ADDR && bit_cnt_q == '0;
   assign rd_start = last_addr && op_q == `TWE_OP_READ;
   assign start_bit = rise && din && state_q == ST_IDLE && !busy_q;
   assign prog_start = sel_fall && armed_q && wen_q && !busy_q;

   // Command sequencer; select low returns it to the start-bit hunt.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= '0;
         op_q <= '0;
         addr_q <= '0;
         data_q <= '0;
      end else if (!sel) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= '0;
      end else if (rise) begin
         case (state_q)
            ST_IDLE: begin
               // Leading zeros fall through here unnoticed.
               if (start_bit) begin
                  state_q <= ST_OPC;
                  bit_cnt_q <= CW'(`TWE_OPC_BITS - 1);
               end
            end
            ST_OPC: begin
               op_q <= {op_q[0], din};
               if (bit_cnt_q == '0) begin
                  state_q <= ST_ADDR;
                  bit_cnt_q <= CW'(CMD_AW - 1);
               end else begin
                  bit_cnt_q <= bit_cnt_q - 1'b1;
               end
            end
            ST_ADDR: begin
               addr_q <= full_addr;
               bit_cnt_q <= bit_cnt_q - 1'b1;
               if (bit_cnt_q == '0) begin
                  bit_cnt_q <= CW'(DW - 1);
                  if (op_q == `TWE_OP_READ) begin
                     state_q <= ST_READ;
                  end else if (op_q == `TWE_OP_WRITE) begin
                     state_q <= ST_DATA;
                  end else if (full_addr[CMD_AW-1 -: 2] == `TWE_EXT_FILL) begin
                     state_q <= ST_DATA;
                  end else begin
                     state_q <= ST_DONE;
                  end
               end
            end
            ST_DATA: begin
               data_q <= {data_q[DW-2:0], din};
               bit_cnt_q <= bit_cnt_q - 1'b1;
               if (bit_cnt_q == '0) begin
                  state_q <= ST_DONE;
               end
            end
            ST_READ: begin
               state_q <= ST_READ;
            end
            ST_DONE: begin
               state_q <= ST_DONE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Write enable latch; power-up locked.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wen_q <= 1'b0;
      end else if (last_addr && op_q == `TWE_OP_EXT) begin
         if (full_addr[CMD_AW-1 -: 2] == `TWE_EXT_WEN) begin
            wen_q <= 1'b1;
         end else if (full_addr[CMD_AW-1 -: 2] == `TWE_EXT_LOCK) begin
            wen_q <= 1'b0;
         end
      end
   end

   // Armed after the last data bit; any further clock rise disarms.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else if (rise && state_q == ST_DATA && bit_cnt_q == '0) begin
         armed_q <= 1'b1;
      end else if (!sel || (rise && state_q == ST_DONE)) begin
         armed_q <= 1'b0;
      end
   end

   // Read fetcher feeds the buffer from incrementing addresses.
   assign push_valid = fetch_on_q;
   assign push_ready = fill_q != 2'(`TWE_BUF_DEPTH);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_on_q <= 1'b0;
         fetch_q <= '0;
      end else if (rd_start) begin
         fetch_on_q <= 1'b1;
         fetch_q <= full_addr[AW-1:0];
      end else if (!sel) begin
         fetch_on_q <= 1'b0;
      end else if (push_valid && push_ready) begin
         fetch_q <= fetch_q + 1'b1;
      end
   end

   // Two-entry buffer, one slot per generate entry.
   for (genvar e = 0; e < `TWE_BUF_DEPTH; e++) begin : g_buf
      always_ff @(posedge core_clk) begin
         if (push_valid && push_ready && wp_q == 1'(e)) begin
            buf_q[e] <= mem_q[fetch_q];
         end
      end
   end

   // Buffer pointers and occupancy; flushed when a read starts or ends.
   assign pop_valid = fill_q != 2'h0;
   assign pop_ready = rise && state_q == ST_READ && sh_cnt_q == '0;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         fill_q <= '0;
      end else if (rd_start || !sel) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         fill_q <= '0;
      end else begin
         if (push_valid && push_ready) begin
            wp_q <= !wp_q;
         end
         if (pop_valid && pop_ready) begin
            rp_q <= !rp_q;
         end
         fill_q <= fill_q + 2'(push_valid && push_ready) - 2'(pop_valid && pop_ready);
      end
   end

   // Output shifter: dummy zero, then words, else the ready level.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dout_q <= 1'b0;
         sh_q <= '0;
         sh_cnt_q <= '0;
      end else if (rd_start) begin
         dout_q <= 1'b0;
         sh_cnt_q <= '0;
      end else if (pop_ready) begin
         dout_q <= pop_valid && buf_q[rp_q][DW-1];
         sh_q <= {buf_q[rp_q][DW-2:0], 1'b0};
         sh_cnt_q <= CW'(DW - 1);
      end else if (rise && state_q == ST_READ) begin
         dout_q <= sh_q[DW-1];
         sh_q <= {sh_q[DW-2:0], 1'b0};
         sh_cnt_q <= sh_cnt_q - 1'b1;
      end else if (state_q != ST_READ) begin
         dout_q <= !busy_q;
      end
   end

   // Status display after a programming command and a long enough low.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
         show_q <= 1'b0;
      end else begin
         if (prog_start) begin
            pend_q <= 1'b1;
         end else if (start_bit) begin
            pend_q <= 1'b0;
         end
         if (!sel || start_bit) begin
            show_q <= 1'b0;
         end else if (sel_rise && low_ok && pend_q) begin
            show_q <= 1'b1;
         end
      end
   end

   // Pad drive: released whenever select is low.
   assign serial_out = dout_q;
   assign serial_out_oe = sel && (show_q || state_q == ST_READ);
   assign write_enabled = wen_q;
   assign program_busy = busy_q;

   // Internal program timer; job captured on the arming select fall.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         prog_cnt_q <= '0;
         job_q <= '0;
      end else if (prog_start) begin
         busy_q <= 1'b1;
         prog_cnt_q <= '0;
         job_q.fill <= op_q == `TWE_OP_EXT;
         job_q.addr <= `TWE_CMD_AW_MAX'(addr_q);
         job_q.data <= data_q;
      end else if (busy_q) begin
         prog_cnt_q <= prog_cnt_q + 1'b1;
         if (prog_cnt_q == PROG_CYCLES - 1) begin
            busy_q <= 1'b0;
         end
      end
   end

   // Erase pass then program pass, one word per cycle at the cycle start.
   assign span = job_q.fill ? 32'(`TWE_BLOCK_WORDS) : 32'h0000_0001;
   assign wr_en = busy_q && prog_cnt_q < 2 * span;
   assign wr_data = (prog_cnt_q < span) ? `TWE_ERASED : job_q.data;
   always_comb begin
      wr_addr = job_q.addr[AW-1:0];
      if (job_q.fill) begin
         wr_addr = AW'((32'(job_q.addr[`TWE_BLK_BITS-1:0]) % NBLK) * `TWE_BLOCK_WORDS
            + (prog_cnt_q % span));
      end
   end

   // Word store; no reset, contents hold across reset.
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // Checks on the sequencer, the pad and the timer.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_sample;
      rise && state_q == ST_OPC && bit_cnt_q == '0 |=> op_q[0] == $past(din);
   endproperty
   a_sample:
   assert property (p_sample) else $error("opcode bit not sampled");

   property p_hiz;
      !sel |-> !serial_out_oe;
   endproperty
   a_hiz:
   assert property (p_hiz) else $error("output driven while deselected");

   property p_seq_reset;
      !sel |=> state_q == ST_IDLE;
   endproperty
   a_seq_reset:
   assert property (p_seq_reset) else $error("sequencer not reset");

   property p_start;
      start_bit |=> state_q == ST_OPC ##0 bit_cnt_q == CW'(1);
   endproperty
   a_start:
   assert property (p_start) else $error("start bit missed");

   property p_zero;
      rise && !din && state_q == ST_IDLE |=> state_q == ST_IDLE;
   endproperty
   a_zero:
   assert property (p_zero) else $error("leading zero taken");

   property p_dummy;
      rd_start |=> !serial_out && serial_out_oe;
   endproperty
   a_dummy:
   assert property (p_dummy) else $error("no dummy zero");

   property p_lock;
      $rose(busy_q) |-> $past(wen_q);
   endproperty
   a_lock:
   assert property (p_lock) else $error("programmed while locked");

   property p_busy_ignore;
      busy_q && state_q == ST_IDLE |=> state_q == ST_IDLE;
   endproperty
   a_busy_ignore:
   assert property (p_busy_ignore) else $error("command taken while busy");

   property p_abandon;
      rise && state_q == ST_DONE |=> !armed_q ##1 !busy_q || $past(busy_q, 2);
   endproperty
   a_abandon:
   assert property (p_abandon) else $error("late fall still programs");

   property p_ready;
      show_q && sel && state_q != ST_READ && !rd_start |=> serial_out == !$past(busy_q);
   endproperty
   a_ready:
   assert property (p_ready) else $error("wrong ready level");

   property p_timer;
      busy_q |-> prog_cnt_q < PROG_CYCLES;
   endproperty
   a_timer:
   assert property (p_timer) else $error("program cycle overran");

   c_read: cover property (rd_start ##[1:400] pop_valid && pop_ready);
   c_prog: cover property (prog_start);
   c_fill: cover property (prog_start && op_q == `TWE_OP_EXT);
   c_ready: cover property (show_q && !busy_q && sel);
endmodule

// [bench/twe_host_model.sv]
// Host-side serial master model that drives the select, clock and data pins.
module twe_host_model (
   // Link pins toward the device.
   output logic chip_sel,
   output logic serial_shift_clock,
   output logic serial_in,
   // Device output and its enable.
   input wire logic serial_out,
   input wire logic serial_out_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   logic do_line;

   // The data line has a pull-up, so a floating output reads high.
   assign do_line = serial_out_oe ? serial_out : 1'b1;

   // The clock stands low outside frames and select starts low.
   initial begin
      chip_sel = 1'b0;
      serial_shift_clock = 1'b0;
      serial_in = 1'b0;
   end

   // Opens a frame after a select low time above the 200 ns minimum.
   // Pins change by non-blocking assignment, so a core edge in the same step sees the old level.
   task automatic open_frame();
      chip_sel <= 1'b0;
      #250;
      chip_sel <= 1'b1;
      #60;
   endtask

   // One 48 ns clock period; returns the line level just before the rise.
   task automatic clock_bit(input logic b, output logic seen);
      serial_in <= b;
      #12;
      seen = do_line;
      serial_shift_clock <= 1'b1;
      #24;
      serial_shift_clock <= 1'b0;
      #12;
   endtask

   // Sends start bit, opcode and address, most significant bit first.
   task automatic send13(input logic [12:0] v);
      logic seen;
      for (int i = 12; i >= 0; i--) begin
         clock_bit(v[i], seen);
      end
   endtask

   // Sends one data word, most significant bit first.
   task automatic send16(input logic [15:0] v);
      logic seen;
      for (int i = 15; i >= 0; i--) begin
         clock_bit(v[i], seen);
      end
   endtask

   // Drops select before the next rise; the data line toggles in the same step.
   task automatic close_frame();
      chip_sel <= 1'b0;
      serial_in <= ~serial_in;
   endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the serial EEPROM command port.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import twe_pkg::*;

   localparam int unsigned PROG = 300;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic chip_sel;
   logic serial_shift_clock;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe;
   logic write_enabled;
   logic program_busy;
   logic wen_model = 1'b0;
   logic [15:0] mem_model [1024];
   logic [31:0] seed_q = 32'hb7ad_f6f0;
   logic [31:0] r;
   int num_errors = 0;
   int comparisons = 0;

   twe_port #(.MEM_WORDS(1024), .PROG_CYCLES(PROG)) dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .chip_sel(chip_sel),
      .serial_shift_clock(serial_shift_clock), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe),
      .write_enabled(write_enabled), .program_busy(program_busy));

   twe_host_model host_u (
      .chip_sel(chip_sel), .serial_shift_clock(serial_shift_clock),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

   // Core clock of 5 ns period.
   always #2.5 core_clk = ~core_clk;

   // Watchdog at about four times the expected run of some 55 us.
   initial begin
      #200000;
      num_errors++;
      results();
   end

   // Xorshift step for repeatable random stimulus.
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic roll();
      seed_q = next_rand(seed_q);
      r = seed_q;
   endtask

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if ($isunknown(got) || got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Checks the start of programming, status display, busy refusal and timing.
   task automatic prog_wait(input logic exp);
      logic seen;
      realtime t0;
      logic in_time;
      t0 = $realtime;
      // Outputs are looked at on the falling edge, where they have settled.
      repeat (10) @(negedge core_clk);
      check("program busy", {15'h0000, exp}, {15'h0000, program_busy});
      if (exp) begin
         host_u.open_frame();
         check("status busy", 16'h0000, {15'h0000, host_u.do_line});
         host_u.clock_bit(1'b1, seen);
         host_u.clock_bit(1'b1, seen);
         check("start ignored", 16'h0000, {15'h0000, host_u.do_line});
         for (int i = 0; i < 1000 && program_busy === 1'b1; i++) begin
            @(negedge core_clk);
         end
         in_time = ($realtime - t0) >= PROG * 5 && ($realtime - t0) <= PROG * 5 + 60;
         check("program time", 16'h0001, {15'h0000, in_time});
         repeat (8) @(negedge core_clk);
         check("status ready", 16'h0001, {15'h0000, host_u.do_line});
      end
      host_u.close_frame();
      #50;
      check("output floats", 16'h0000, {15'h0000, serial_out_oe});
   endtask

   // Extended command with random leading zeros and random don't-care bits.
   task automatic ext_cmd(input logic [1:0] code);
      logic seen;
      roll();
      host_u.open_frame();
      for (int i = 0; i < r[9:8]; i++) begin
         host_u.clock_bit(1'b0, seen);
      end
      host_u.send13({3'h4, code, r[7:0]});
      host_u.close_frame();
      repeat (20) @(negedge core_clk);
      wen_model = (code == 2'h3) ? 1'b1 : (code == 2'h0) ? 1'b0 : wen_model;
      check("write enable", {15'h0000, wen_model}, {15'h0000, write_enabled});
   endtask

   task automatic write_word(input logic [9:0] a, input logic [15:0] d, input logic abandon);
      logic seen;
      host_u.open_frame();
      host_u.send13({3'h5, a});
      host_u.send16(d);
      if (abandon) begin
         host_u.clock_bit(1'b0, seen);
      end
      host_u.close_frame();
      if (wen_model && !abandon) begin
         mem_model[a] = d;
      end
      prog_wait(wen_model && !abandon);
   endtask

   task automatic fill(input logic [2:0] blk, input logic [15:0] d);
      roll();
      host_u.open_frame();
      host_u.send13({3'h4, 2'h1, r[4:0], blk});
      host_u.send16(d);
      host_u.close_frame();
      for (int i = 0; i < 128 && wen_model; i++) begin
         mem_model[{blk, 7'(i)}] = d;
      end
      prog_wait(wen_model);
   endtask

   // Reads two consecutive words after the dummy bit.
   task automatic read_check(input logic [9:0] a);
      logic seen;
      logic [31:0] got;
      roll();
      host_u.open_frame();
      host_u.send13({3'h6, a});
      host_u.clock_bit(r[0], seen);
      check("dummy bit", 16'h0000, {15'h0000, seen});
      for (int i = 0; i < 32; i++) begin
         host_u.clock_bit(r[i], seen);
         got = {got[30:0], seen};
      end
      host_u.close_frame();
      #50;
      check("read word", mem_model[a], got[31:16]);
      check("next word", mem_model[a + 10'h001], got[15:0]);
   endtask

   // Main sequence.
   initial begin
      logic [9:0] a;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (5) @(negedge core_clk);
      check("reset enable", 16'h0000, {15'h0000, write_enabled});
      check("reset oe", 16'h0000, {15'h0000, serial_out_oe});
      $display("test reset done");
      roll();
      write_word(r[9:0], r[31:16], 1'b0);
      ext_cmd(2'h3);
      // The unused extended code must leave the enable latch alone.
      ext_cmd(2'h2);
      $display("test lock and enable done");
      for (int k = 0; k < 3; k++) begin
         roll();
         a = (k == 0) ? 10'h3ff : r[9:0];
         write_word(a, (k == 0) ? 16'h0000 : r[31:16], 1'b0);
         roll();
         write_word(a + 10'h001, r[15:0], 1'b0);
         read_check(a);
      end
      write_word(10'h3ff, 16'hffff, 1'b0);
      read_check(10'h3ff);
      $display("test word writes done");
      roll();
      // The block is kept aside, since the tasks below roll new values.
      a = {r[2:0], 7'h00};
      fill(a[9:7], r[31:16]);
      read_check(a);
      read_check(a + 10'h07e);
      $display("test block fill done");
      roll();
      write_word(10'h3ff, r[15:0], 1'b1);
      read_check(10'h3ff);
      ext_cmd(2'h0);
      write_word(10'h3ff, r[31:16], 1'b0);
      read_check(10'h3ff);
      $display("test abandon and lock done");
      results();
   end
endmodule
